// file: core/split_timer.sv
`timescale 1ns/1ps
// Operation
// - base mode: 16-bit reload counter, blockable overflow
// - enabled falling trigger edge sets external flag
// - trigger picked from eight sources by selector
// - enabled rising trigger edge acts like falling
// - one-cycle overflow event pulse exported
// - reload mode: overflow at all ones reloads
// - enabled edge also reloads, sets external flag
// - irq when overflow or external flag set
// - capture mode: edge copies count, sets flag
// - auto-zero capture also clears the count
// - duty mode: hold counter until first edge
// - duty first edge rising, never sets flag
// - duty second edge captures, flag if fall enabled
// - duty third edge clears run, freezes count
// - split: two 8-bit counters, own reloads/clocks
// - split: run gates high, low run gates low
// - autoclear: high overflow (capture edge in capture modes) stops the low counter
// - split flags: high blockable, low enable-gated
// - flags cleared only by software writes
// - split exports low-byte overflow as event
// - mode bit six: fast select or invert
// - split modes apply 16-bit behaviour to the high byte only
`include "split_timer_defines.svh"

module split_timer
    import split_timer_pkg::*;
#(
    parameter int SYSCLK_DIV = `TMR_SYSCLK_DIV
) (
    input wire logic i_clk,                // system clock
    input wire logic i_rst_n,              // synchronous reset, active low
    input wire logic i_wb_cyc,             // wishbone cycle
    input wire logic i_wb_stb,             // wishbone strobe
    input wire logic i_wb_we,              // wishbone write enable
    input wire logic [7:0] i_wb_adr,       // wishbone byte address
    input wire logic [3:0] i_wb_sel,       // wishbone byte enables
    input wire logic [31:0] i_wb_dat,      // wishbone write data
    output logic [31:0] o_wb_dat,          // wishbone read data
    output logic o_wb_ack,                 // wishbone acknowledge
    input wire logic i_cnt_pin,            // counter pin level
    input wire logic [4:0] i_hi_evt,       // high clock event pulses
    input wire logic [1:0] i_lo_evt,       // low clock event pulses
    input wire logic [7:0] i_ext_trig,     // external trigger candidates
    output logic o_irq,                    // timer interrupt request
    output logic o_ovf_event,              // overflow event pulse
    output logic o_ext_edge_event          // accepted trigger edge pulse
);

    // divider compare register is eight bits wide
    if (SYSCLK_DIV < 2 || SYSCLK_DIV > 255) begin : g_div_check
        $error("SYSCLK_DIV out of range");
    end

    localparam logic [7:0] DIV_LAST = 8'(SYSCLK_DIV - 1);

    function automatic logic pick8(input logic [7:0] src, input logic [2:0] sel);
        pick8 = src[sel];
    endfunction : pick8

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] mode_reg, mode_next;
    logic [7:0] mode1_reg, mode1_next;
    logic low_fast_reg, low_fast_next;
    logic invert_reg, invert_next;
    logic [7:0] cnt_low_reg, cnt_low_next;
    logic [7:0] cnt_high_reg, cnt_high_next;
    logic [7:0] rcap_low_reg, rcap_low_next;
    logic [7:0] rcap_high_reg, rcap_high_next;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] mode_rd;

    assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg && i_wb_sel[0];
    assign wbyte = i_wb_dat[7:0];
    // bit six reads back whichever function is selected
    assign mode_rd = {mode_reg[7],
                      mode1_reg[`MODE1_ALT_BIT_SEL] ? invert_reg : low_fast_reg,
                      mode_reg[5:0]};

    always_comb begin
        ack_next = i_wb_cyc && i_wb_stb && !ack_reg;
        rdat_next = rdat_reg;
        if (i_wb_cyc && i_wb_stb && !ack_reg) begin
            case (i_wb_adr)
                `TMR_CTRL_OFS: rdat_next = {24'h000000, ctrl_reg};
                `TMR_MODE_OFS: rdat_next = {24'h000000, mode_rd};
                `TMR_MODE1_OFS: rdat_next = {24'h000000, mode1_reg};
                `TMR_CNT_LOW_OFS: rdat_next = {24'h000000, cnt_low_reg};
                `TMR_CNT_HIGH_OFS: rdat_next = {24'h000000, cnt_high_reg};
                `TMR_RCAP_LOW_OFS: rdat_next = {24'h000000, rcap_low_reg};
                `TMR_RCAP_HIGH_OFS: rdat_next = {24'h000000, rcap_high_reg};
                default: rdat_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    // ------------------------------------------------------------
    // clock sources and trigger sampling
    // ------------------------------------------------------------
    logic [7:0] div_reg, div_next;
    logic pin_prev_reg, pin_prev_next;
    logic trig_prev_reg, trig_prev_next;
    logic div_tick, pin_rise, trig_now, trig_rise, trig_fall;

    assign div_tick = (div_reg == DIV_LAST);
    assign pin_rise = i_cnt_pin && !pin_prev_reg;
    assign trig_now = pick8(i_ext_trig, mode1_reg[`MODE1_EXT_SRC_SEL_MSB:0]) ^ invert_reg;
    assign trig_rise = trig_now && !trig_prev_reg;
    assign trig_fall = !trig_now && trig_prev_reg;

    always_comb begin
        div_next = div_tick ? 8'h00 : 8'(div_reg + 8'h01);
        pin_prev_next = i_cnt_pin;
        trig_prev_next = trig_now;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            div_reg <= 8'h00;
            pin_prev_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            pin_prev_reg <= pin_prev_next;
            trig_prev_reg <= trig_prev_next;
        end
    end

    // ------------------------------------------------------------
    // mode and clock selection
    // ------------------------------------------------------------
    logic split;
    mode_type mode;
    logic [2:0] hi_code;
    logic [1:0] lo_code;
    logic [7:0] hi_src;
    logic [3:0] lo_src;
    logic low_ovf_tick;
    logic hi_tick, lo_tick;

    assign split = mode_reg[`MODE_SPLIT_EN];
    assign mode = mode_type'({mode1_reg[`MODE1_MODE_SEL_B1],
                              ctrl_reg[`CTRL_CAPTURE_RELOAD_SEL],
                              mode_reg[`MODE_MODE_SEL_B0]});
    assign hi_code = {mode1_reg[`MODE1_CLK_SRC_SEL_HI], mode_reg[`MODE_FAST_CLK_SEL],
                      ctrl_reg[`CTRL_COUNTER_SEL]};
    assign lo_code = {mode1_reg[`MODE1_LOW_CLK_SRC_SEL], low_fast_reg};
    // in split operation code 011 counts low-byte overflows
    assign hi_src = {i_hi_evt[4:1], split ? low_ovf_tick : i_hi_evt[0],
                     1'b1, pin_rise, div_tick};
    assign lo_src = {i_lo_evt[1], i_lo_evt[0], 1'b1, div_tick};
    assign lo_tick = split && mode_reg[`MODE_RUN_LOW]
                     && pick8({4'h0, lo_src}, {1'b0, lo_code});
    assign low_ovf_tick = lo_tick && (cnt_low_reg == 8'hFF);

    // ------------------------------------------------------------
    // timer core
    // ------------------------------------------------------------
    duty_state_type duty_reg, duty_next;
    logic ovf_evt_reg, ovf_evt_next;
    logic edge_evt_reg, edge_evt_next;
    logic is_duty, running, hi_ovf, edge_act;
    logic set_ovf, set_ext, set_low_ovf, clr_run_high, clr_run_low;
    logic [15:0] cnt16;

    assign is_duty = (mode == MODE_DUTY);
    assign running = ctrl_reg[`CTRL_RUN_HIGH]
                     && (!is_duty || duty_reg == DUTY_WAIT_SECOND
                         || duty_reg == DUTY_WAIT_THIRD);
    assign hi_tick = running && pick8(hi_src, hi_code);
    assign cnt16 = {cnt_high_reg, cnt_low_reg};
    assign hi_ovf = hi_tick && (split ? cnt_high_reg == 8'hFF : cnt16 == 16'hFFFF);
    assign edge_act = !is_duty && ((trig_fall && ctrl_reg[`CTRL_FALL_EDGE_EN])
                      || (trig_rise && mode_reg[`MODE_RISE_EDGE_EN]));

    always_comb begin
        cnt_low_next = cnt_low_reg;
        cnt_high_next = cnt_high_reg;
        rcap_low_next = rcap_low_reg;
        rcap_high_next = rcap_high_reg;
        duty_next = duty_reg;
        set_ovf = hi_ovf;
        set_ext = edge_act;
        set_low_ovf = low_ovf_tick;
        clr_run_high = 1'b0;
        clr_run_low = 1'b0;
        // counting
        if (split) begin
            if (hi_tick) begin
                cnt_high_next = 8'(cnt_high_reg + 8'h01);
            end
            if (lo_tick) begin
                cnt_low_next = low_ovf_tick ? rcap_low_reg
                                            : 8'(cnt_low_reg + 8'h01);
            end
        end else if (hi_tick) begin
            cnt_low_next = cnt16[7:0] + 8'h01;
            cnt_high_next = 8'((cnt16 + 16'h0001) >> 8);
        end
        // overflow reload, capture modes roll over to zero
        if (hi_ovf && (mode == MODE_AR || mode == MODE_AR_EXT || mode == MODE_PWM)) begin
            cnt_high_next = rcap_high_reg;
            if (!split) begin
                cnt_low_next = rcap_low_reg;
            end
        end
        // accepted trigger edge
        if (edge_act) begin
            case (mode)
                MODE_AR_EXT: begin
                    cnt_high_next = rcap_high_reg;
                    if (!split) begin
                        cnt_low_next = rcap_low_reg;
                    end
                end
                MODE_CAP, MODE_CAP_ZERO: begin
                    rcap_high_next = cnt_high_reg;
                    if (!split) begin
                        rcap_low_next = cnt_low_reg;
                    end
                    if (mode == MODE_CAP_ZERO) begin
                        cnt_high_next = 8'h00;
                        if (!split) begin
                            cnt_low_next = 8'h00;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // duty capture sequence
        if (!is_duty || !ctrl_reg[`CTRL_RUN_HIGH]) begin
            duty_next = DUTY_WAIT_FIRST;
        end else begin
            case (duty_reg)
                DUTY_WAIT_FIRST: begin
                    if (trig_rise) begin
                        duty_next = DUTY_WAIT_SECOND;
                    end
                end
                DUTY_WAIT_SECOND: begin
                    if (trig_rise || trig_fall) begin
                        duty_next = DUTY_WAIT_THIRD;
                        rcap_high_next = cnt_high_reg;
                        if (!split) begin
                            rcap_low_next = cnt_low_reg;
                        end
                        set_ext = ctrl_reg[`CTRL_FALL_EDGE_EN];
                    end
                end
                DUTY_WAIT_THIRD: begin
                    if (trig_rise || trig_fall) begin
                        duty_next = DUTY_DONE;
                        clr_run_high = 1'b1;
                        cnt_high_next = cnt_high_reg;
                        cnt_low_next = split ? cnt_low_next : cnt_low_reg;
                        set_ext = mode_reg[`MODE_RISE_EDGE_EN];
                    end
                end
                DUTY_DONE: duty_next = DUTY_DONE;
                default: duty_next = DUTY_WAIT_FIRST;
            endcase
        end
        // low run auto-clear
        if (split && mode_reg[`MODE_RUN_LOW_AUTOCLEAR]) begin
            if (mode == MODE_CAP || mode == MODE_CAP_ZERO) begin
                clr_run_low = edge_act;
            end else begin
                clr_run_low = hi_ovf;
            end
        end
        // software register writes
        ctrl_next = ctrl_reg;
        mode_next = mode_reg;
        mode1_next = mode1_reg;
        low_fast_next = low_fast_reg;
        invert_next = invert_reg;
        if (wr_en) begin
            case (i_wb_adr)
                `TMR_CTRL_OFS: ctrl_next = wbyte;
                `TMR_MODE_OFS: begin
                    mode_next = wbyte;
                    if (mode1_reg[`MODE1_ALT_BIT_SEL]) begin
                        invert_next = wbyte[`MODE_ALT_BIT6];
                    end else begin
                        low_fast_next = wbyte[`MODE_ALT_BIT6];
                    end
                end
                `TMR_MODE1_OFS: mode1_next = wbyte;
                `TMR_CNT_LOW_OFS: cnt_low_next = wbyte;
                `TMR_CNT_HIGH_OFS: cnt_high_next = wbyte;
                `TMR_RCAP_LOW_OFS: rcap_low_next = wbyte;
                `TMR_RCAP_HIGH_OFS: rcap_high_next = wbyte;
                default: begin
                end
            endcase
        end
        mode_next[`MODE_ALT_BIT6] = 1'b0;
        // hardware sets win over software clears
        ctrl_next[`CTRL_OVF_FLAG] = ctrl_next[`CTRL_OVF_FLAG] | set_ovf;
        ctrl_next[`CTRL_EXT_FLAG] = ctrl_next[`CTRL_EXT_FLAG] | set_ext;
        ctrl_next[`CTRL_LOW_OVF_FLAG] = ctrl_next[`CTRL_LOW_OVF_FLAG] | set_low_ovf;
        if (clr_run_high) begin
            ctrl_next[`CTRL_RUN_HIGH] = 1'b0;
        end
        if (clr_run_low) begin
            mode_next[`MODE_RUN_LOW] = 1'b0;
        end
        ovf_evt_next = split ? low_ovf_tick : hi_ovf;
        edge_evt_next = set_ext;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_reg <= `TMR_REG_RESET;
            mode_reg <= `TMR_REG_RESET;
            mode1_reg <= `TMR_REG_RESET;
            low_fast_reg <= 1'b0;
            invert_reg <= 1'b0;
            cnt_low_reg <= `TMR_REG_RESET;
            cnt_high_reg <= `TMR_REG_RESET;
            rcap_low_reg <= `TMR_REG_RESET;
            rcap_high_reg <= `TMR_REG_RESET;
            duty_reg <= DUTY_WAIT_FIRST;
            ovf_evt_reg <= 1'b0;
            edge_evt_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
            mode1_reg <= mode1_next;
            low_fast_reg <= low_fast_next;
            invert_reg <= invert_next;
            cnt_low_reg <= cnt_low_next;
            cnt_high_reg <= cnt_high_next;
            rcap_low_reg <= rcap_low_next;
            rcap_high_reg <= rcap_high_next;
            duty_reg <= duty_next;
            ovf_evt_reg <= ovf_evt_next;
            edge_evt_reg <= edge_evt_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_ovf_event = ovf_evt_reg;
    assign o_ext_edge_event = edge_evt_reg;
    assign o_irq = (ctrl_reg[`CTRL_OVF_FLAG] && !mode1_reg[`MODE1_OVF_IRQ_BLOCK])
                   || ctrl_reg[`CTRL_EXT_FLAG]
                   || (split && ctrl_reg[`CTRL_LOW_OVF_FLAG]
                       && ctrl_reg[`CTRL_LOW_OVF_IRQ_EN]);

endmodule : split_timer

// file: inc/split_timer_defines.svh
`ifndef SPLIT_TIMER_DEFINES_SVH
`define SPLIT_TIMER_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TMR_CTRL_OFS 8'h00
`define TMR_MODE_OFS 8'h04
`define TMR_MODE1_OFS 8'h08
`define TMR_CNT_LOW_OFS 8'h0C
`define TMR_CNT_HIGH_OFS 8'h10
`define TMR_RCAP_LOW_OFS 8'h14
`define TMR_RCAP_HIGH_OFS 8'h18

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_OVF_FLAG 7
`define CTRL_EXT_FLAG 6
`define CTRL_LOW_OVF_FLAG 5
`define CTRL_LOW_OVF_IRQ_EN 4
`define CTRL_FALL_EDGE_EN 3
`define CTRL_RUN_HIGH 2
`define CTRL_COUNTER_SEL 1
`define CTRL_CAPTURE_RELOAD_SEL 0

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define MODE_SPLIT_EN 7
`define MODE_ALT_BIT6 6
`define MODE_RISE_EDGE_EN 5
`define MODE_FAST_CLK_SEL 4
`define MODE_RUN_LOW 3
`define MODE_RUN_LOW_AUTOCLEAR 2
`define MODE_CLKOUT_EN 1
`define MODE_MODE_SEL_B0 0

// ------------------------------------------------------------
// mode register 1 fields
// ------------------------------------------------------------
`define MODE1_LOW_CLK_SRC_SEL 7
`define MODE1_OVF_IRQ_BLOCK 6
`define MODE1_ALT_BIT_SEL 5
`define MODE1_CLK_SRC_SEL_HI 4
`define MODE1_MODE_SEL_B1 3
`define MODE1_EXT_SRC_SEL_MSB 2

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define TMR_REG_RESET 8'h00
`define TMR_SYSCLK_DIV 12

`endif

// file: inc/split_timer_pkg.sv
package split_timer_pkg;

    typedef enum logic [2:0] {
        MODE_AR = 3'b000,
        MODE_AR_EXT = 3'b001,
        MODE_CAP = 3'b010,
        MODE_CAP_ZERO = 3'b011,
        MODE_PWM = 3'b100,
        MODE_RSVD5 = 3'b101,
        MODE_DUTY = 3'b110,
        MODE_RSVD7 = 3'b111
    } mode_type;

    typedef enum logic [3:0] {
        DUTY_WAIT_FIRST = 4'b0001,
        DUTY_WAIT_SECOND = 4'b0010,
        DUTY_WAIT_THIRD = 4'b0100,
        DUTY_DONE = 4'b1000
    } duty_state_type;

endpackage : split_timer_pkg

// file: dv/split_timer_asserts.sv
`timescale 1ns/1ps
module split_timer_asserts (
    input wire logic i_clk,               // clock
    input wire logic i_rst_n,             // reset, active low
    input wire logic i_wb_cyc,            // bus cycle
    input wire logic i_wb_stb,            // bus strobe
    input wire logic i_wb_we,             // bus write
    input wire logic [31:0] o_wb_dat,     // read data
    input wire logic o_wb_ack,            // acknowledge
    input wire logic [7:0] i_ext_trig,    // trigger candidates
    input wire logic o_irq,               // interrupt
    input wire logic o_ovf_event,         // overflow pulse
    input wire logic o_ext_edge_event     // edge pulse
);
    logic [7:0] trig_q;
    logic [3:0] since_chg;
    logic [1:0] wr_hist;
    logic wr_now;

    assign wr_now = i_wb_cyc && i_wb_stb && i_wb_we;

    // cycles since trigger inputs moved, recent writes
    always_ff @(posedge i_clk) begin
        trig_q <= i_ext_trig;
        if (!i_rst_n) begin
            since_chg <= 4'hF;
            wr_hist <= 2'h0;
        end else begin
            wr_hist <= {wr_hist[0], wr_now};
            if (i_ext_trig != trig_q) since_chg <= 4'h0;
            else if (since_chg != 4'hF) since_chg <= since_chg + 4'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    ack_pulse_a:
        assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
    ack_latency_a:
        assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack not one cycle after request");
    ack_cause_a:
        assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc) && $past(i_wb_stb))
        else $error("ack without request");
    dat_upper_a:
        assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
        else $error("read data upper bits set");
    dat_hold_a:
        assert property (!i_wb_stb |=> $stable(o_wb_dat)) else $error("read data moved");
    ext_irq_a:
        assert property (o_ext_edge_event |-> o_irq) else $error("edge without irq");
    irq_clear_a:
        assert property ($fell(o_irq) |-> wr_now || wr_hist != 2'h0)
        else $error("irq dropped without write");
    ext_cause_a:
        assert property (o_ext_edge_event |-> since_chg <= 4'h3)
        else $error("edge event without trigger change");
    reset_quiet_a:
        assert property ($rose(i_rst_n) |-> !o_wb_ack && !o_irq && !o_ovf_event)
        else $error("outputs active after reset");
endmodule : split_timer_asserts

bind split_timer split_timer_asserts split_timer_asserts_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_ext_trig(i_ext_trig), .o_irq(o_irq), .o_ovf_event(o_ovf_event),
    .o_ext_edge_event(o_ext_edge_event)
);

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "split_timer_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t mismatch got %0h exp %0h", $time, (g), (e)); end end

module testbench;
    localparam logic [7:0] CT = `TMR_CTRL_OFS, MD = `TMR_MODE_OFS, M1 = `TMR_MODE1_OFS;
    localparam logic [7:0] CL = `TMR_CNT_LOW_OFS, CH = `TMR_CNT_HIGH_OFS;
    localparam logic [7:0] RL = `TMR_RCAP_LOW_OFS, RH = `TMR_RCAP_HIGH_OFS;
    logic clk, rst_n, cyc, stb, we, ack, irq, ovf, ext, pin;
    logic [7:0] adr, trig;
    logic [31:0] wdat, rdat;
    logic [4:0] hev;
    logic [1:0] lev;
    int bad_count, cmp_count, cycles, n_ovf, n_ext;

    split_timer split_timer_i (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_cnt_pin(pin), .i_hi_evt(hev), .i_lo_evt(lev), .i_ext_trig(trig),
        .o_irq(irq), .o_ovf_event(ovf), .o_ext_edge_event(ext));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (ovf === 1'b1) n_ovf++;
        if (ext === 1'b1) n_ext++;
        if (cycles == 5000) begin
            bad_count++;
            $display("ERROR %0t timeout", $time);
            summarize();
        end
    end

    task summarize;
        $display("compares %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask : rd

    // one-cycle clock pulses on the high or low byte source
    task pulse(input logic lo, input int k);
        repeat (k) begin
            @(posedge clk);
            if (lo) lev <= 2'h1;
            else hev <= 5'h02;
            @(posedge clk);
            lev <= 2'h0;
            hev <= 5'h00;
        end
    endtask : pulse

    task edge_to(input int b, input logic v);
        @(posedge clk);
        trig[b] <= v;
        repeat (4) @(posedge clk);
    endtask : edge_to

    task t_regs;
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 8'h00);
        wr(8'h40, 8'h5A);
        rd(8'h40, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task t_base;
        int o;
        wr(M1, 8'h10); wr(RH, 8'h12); wr(RL, 8'h34); wr(CH, 8'hFF); wr(CL, 8'hFE); wr(CT, 8'h04);
        o = n_ovf;
        pulse(1'b0, 2);
        rd(CL, 8'h34);
        rd(CH, 8'h12);
        `CHK(n_ovf - o, 1)
        `CHK(irq, 1'b1)
        rd(CT, 8'h84);
        wr(CT, 8'h04); wr(M1, 8'h50); wr(CL, 8'hFF); wr(CH, 8'hFF);
        pulse(1'b0, 1);
        rd(CT, 8'h84);
        `CHK(irq, 1'b0)
        $display("test base done");
    endtask : t_base

    task t_src;
        int o;
        wr(CT, 8'h00); wr(MD, 8'h01); wr(M1, 8'h10); wr(RL, 8'h5A); wr(CL, 8'h11); wr(CT, 8'h0C);
        o = n_ext;
        for (int s = 0; s < 8; s++) begin
            wr(M1, 8'(8'h10 + s));
            edge_to((s + 1) % 8, 1'b0);
            edge_to((s + 1) % 8, 1'b1);
            edge_to(s, 1'b0);
            edge_to(s, 1'b1);
        end
        `CHK(n_ext - o, 8)
        rd(CL, 8'h5A);
        rd(CT, 8'h4C);
        wr(CT, 8'h04); wr(MD, 8'h21);
        o = n_ext;
        edge_to(7, 1'b0);
        edge_to(7, 1'b1);
        `CHK(n_ext - o, 1)
        $display("test source done");
    endtask : t_src

    task t_cap;
        wr(CT, 8'h00); wr(MD, 8'h00); wr(M1, 8'h17); wr(CH, 8'h00); wr(CL, 8'h00); wr(CT, 8'h0D);
        pulse(1'b0, 5);
        edge_to(7, 1'b0);
        rd(RL, 8'h05);
        rd(RH, 8'h00);
        rd(CL, 8'h05);
        wr(MD, 8'h01);
        edge_to(7, 1'b1);
        pulse(1'b0, 2);
        edge_to(7, 1'b0);
        rd(RL, 8'h07);
        rd(CL, 8'h00);
        $display("test capture done");
    endtask : t_cap

    task t_duty;
        int o;
        wr(CT, 8'h00); wr(MD, 8'h20); wr(M1, 8'h1F); wr(CH, 8'h00); wr(CL, 8'h00); wr(CT, 8'h0D);
        pulse(1'b0, 3);
        rd(CL, 8'h00);
        o = n_ext;
        edge_to(7, 1'b1);
        `CHK(n_ext - o, 0)
        pulse(1'b0, 4);
        edge_to(7, 1'b0);
        `CHK(n_ext - o, 1)
        rd(RL, 8'h04);
        pulse(1'b0, 2);
        edge_to(7, 1'b1);
        pulse(1'b0, 2);
        rd(CT, 8'h49);
        rd(CL, 8'h06);
        $display("test duty done");
    endtask : t_duty

    task t_split;
        int o;
        wr(CT, 8'h00); wr(M1, 8'h97); wr(MD, 8'h8C); wr(CL, 8'hFF); wr(CH, 8'hFE);
        wr(RL, 8'h20); wr(RH, 8'h40); wr(CT, 8'h14);
        o = n_ovf;
        pulse(1'b1, 1);
        rd(CL, 8'h20);
        rd(CH, 8'hFE);
        `CHK(n_ovf - o, 1)
        `CHK(irq, 1'b1)
        pulse(1'b0, 2);
        rd(CH, 8'h40);
        `CHK(n_ovf - o, 1)
        rd(MD, 8'h84);
        rd(CT, 8'hB4);
        wr(MD, 8'h88); wr(CT, 8'h10);
        pulse(1'b0, 1);
        pulse(1'b1, 1);
        rd(CH, 8'h40);
        rd(CL, 8'h21);
        $display("test split done");
    endtask : t_split

    // divided, pin and system clock sources, trigger inversion
    task t_clk;
        wr(CT, 8'h00); wr(MD, 8'h00); wr(M1, 8'h00); wr(CL, 8'h00); wr(CT, 8'h04);
        repeat (2 * `TMR_SYSCLK_DIV - 1) @(posedge clk);
        wr(CT, 8'h00);
        rd(CL, 8'h02);
        wr(CL, 8'h00); wr(CT, 8'h06);
        repeat (3) begin
            @(posedge clk) pin <= 1'b1;
            @(posedge clk) pin <= 1'b0;
        end
        rd(CL, 8'h03);
        wr(CT, 8'h00); wr(CL, 8'h00); wr(MD, 8'h10); wr(CT, 8'h04);
        rd(CL, 8'h01);
        wr(CT, 8'h00); wr(M1, 8'h27); wr(MD, 8'h40); wr(CT, 8'h08);
        rd(MD, 8'h40);
        edge_to(7, 1'b0);
        rd(CT, 8'h08);
        edge_to(7, 1'b1);
        rd(CT, 8'h48);
        wr(M1, 8'h07);
        rd(MD, 8'h00);
        $display("test clock done");
    endtask : t_clk

    initial begin
        rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
        trig = 8'h00; hev = 5'h00; lev = 2'h0; pin = 1'b0;
        bad_count = 0; cmp_count = 0; cycles = 0; n_ovf = 0; n_ext = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        trig <= 8'hFF;
        t_regs; t_base; t_src; t_cap; t_duty; t_split; t_clk;
        summarize();
    end
endmodule : testbench
